// [core/banked_data_memory_decode.sv]
// Banked data memory decoder with indirect ports and program access
// Behaviour
// - Pointer high bit 7 selects program memory
// - Program read returns low eight bits only
// - Indirect writes never change program memory
// - Program access takes one extra cycle
// - Core registers repeat in every bank
// - Offsets 70h-7Fh alias common bytes
// - Unimplemented locations read as zero
// - Converter registers in bank 14 alias bank 1
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module banked_data_memory_decode #(
  parameter int PROG_WIDTH = 14
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [15:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Program memory loader
  input  wire logic                  progLoadEn,
  input  wire logic [11:0]           progLoadAddr,
  input  wire logic [PROG_WIDTH-1:0] progLoadData,
  // Status
  output logic [4:0]                 bankSelect,
  output logic                       progAccess
);
  if (PROG_WIDTH < 8) begin : gWidthCheck
    $error("program word narrower than a byte");
  end

  // ---------------------------------------------------------------
  // Core registers
  // ---------------------------------------------------------------
  logic [7:0] ptr0Low_reg, ptr0High_reg, ptr1Low_reg, ptr1High_reg;
  logic [7:0] bankSel_reg;
  logic [7:0] coreMisc_reg [3];   // 09h..0Bh kept as plain bytes
  logic [7:0] convReg_reg  [5];   // Converter result/control
  bdm_pkg::acc_state_t state_reg;
  logic       progSeen_reg;
  logic [7:0] rdata_reg;
  logic       ack_reg;

  mem_if #(.AW(12)) ramBus ();
  mem_if #(.AW(12)) romBus ();

  bdm_ram #(.DEPTH(256)) uRam (
    .mclk (mclk),
    .port (ramBus.slave)
  );

  bdm_prog_rom #(.DEPTH(4096), .WIDTH(PROG_WIDTH)) uRom (
    .mclk     (mclk),
    .loadEn   (progLoadEn),
    .loadAddr (progLoadAddr),
    .loadData (progLoadData),
    .port     (romBus.slave)
  );

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  logic        req;
  logic        isCore;
  logic        isInd;
  logic [15:0] dataAddr;     // Linear data address
  logic [7:0]  wByte;
  logic        wrEn;

  // Taken only while no answer is pending
  assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wByte  = wb_dat_i[7:0];
  assign wrEn   = req && wb_we_i && wb_sel_i[0];

  always_comb begin
    isCore   = 1'b0;
    isInd    = 1'b0;
    dataAddr = 16'h0000;
    if (wb_adr_i[15:14] == bdm_pkg::WB_CORE_BASE[15:14] &&
        wb_adr_i[1:0] == 2'b00) begin
      isCore   = 1'b1;
      dataAddr = {4'h0, wb_adr_i[13:2]};
    end else if (wb_adr_i == bdm_pkg::WB_IND_CMD ||
                 wb_adr_i == bdm_pkg::WB_IND_STAT) begin
      isInd = 1'b1;
    end
  end

  // Direct or indirect resolution
  logic [6:0]  offset;
  logic [4:0]  bank;
  logic        viaInd;
  logic [7:0]  ptrLow, ptrHigh;
  logic [14:0] effAddr;
  logic        effProg;

  assign offset = dataAddr[6:0];
  assign viaInd = isCore && (offset == bdm_pkg::OFS_PORT_ZERO ||
                             offset == bdm_pkg::OFS_PORT_ONE);
  assign ptrLow  = offset[0] ? ptr1Low_reg  : ptr0Low_reg;
  assign ptrHigh = offset[0] ? ptr1High_reg : ptr0High_reg;
  assign effProg = viaInd && ptrHigh[bdm_pkg::PROG_SEL_BIT];

  always_comb begin
    if (viaInd) begin
      effAddr = {ptrHigh[6:0], ptrLow};
    end else begin
      effAddr = {3'b000, dataAddr[11:0]};
    end
  end

  assign bank = effAddr[11:7];

  // ---------------------------------------------------------------
  // Target selection for resolved data address
  // ---------------------------------------------------------------
  logic [6:0] tOfs;
  logic       tCore, tRam, tConv;
  logic [7:0] ramIdx;
  logic [2:0] convIdx;

  assign tOfs = effAddr[6:0];

  always_comb begin
    tCore   = 1'b0;
    tRam    = 1'b0;
    tConv   = 1'b0;
    ramIdx  = 8'h00;
    convIdx = 3'h0;
    if (effAddr[14:12] != 3'b000) begin
      tCore = 1'b0;
    end else if (tOfs <= bdm_pkg::OFS_CORE_LAST) begin
      tCore = 1'b1;
    end else if (tOfs >= bdm_pkg::OFS_COMMON_LO) begin
      tRam   = 1'b1;
      ramIdx = {4'hF, tOfs[3:0]};
    end else if (tOfs >= bdm_pkg::OFS_GPR_LO &&
                 bank < 5'(bdm_pkg::GPR_BANKS)) begin
      tRam   = 1'b1;
      // Per-bank slices packed back to back in storage
      ramIdx = 8'(bank * 80 + 32'(tOfs - bdm_pkg::OFS_GPR_LO));
    end else if (tOfs >= bdm_pkg::OFS_CONV_LO &&
                 tOfs <= bdm_pkg::OFS_CONV_HI &&
                 (bank == bdm_pkg::BANK_CONV_MAIN ||
                  bank == bdm_pkg::BANK_CONV_ALIAS)) begin
      tConv   = 1'b1;
      convIdx = 3'(tOfs - bdm_pkg::OFS_CONV_LO);
    end
  end

  // Core register readback
  logic [7:0] coreRd;
  always_comb begin
    coreRd = 8'h00;
    if (tOfs[3:0] == bdm_pkg::OFS_PTR0_LOW[3:0]) begin
      coreRd = ptr0Low_reg;
    end else if (tOfs[3:0] == bdm_pkg::OFS_PTR0_HIGH[3:0]) begin
      coreRd = ptr0High_reg;
    end else if (tOfs[3:0] == bdm_pkg::OFS_PTR1_LOW[3:0]) begin
      coreRd = ptr1Low_reg;
    end else if (tOfs[3:0] == bdm_pkg::OFS_PTR1_HIGH[3:0]) begin
      coreRd = ptr1High_reg;
    end else if (tOfs[3:0] == bdm_pkg::OFS_BANK_SEL[3:0]) begin
      coreRd = bankSel_reg;
    end else if (tOfs[3:0] >= 4'h9) begin
      coreRd = coreMisc_reg[2'(tOfs[3:0] - 4'h9)];
    end
  end

  // Nested indirect through the ports themselves reads as zero
  logic coreWr;
  assign coreWr = wrEn && tCore && !effProg &&
                  tOfs > bdm_pkg::OFS_PORT_ONE;

  assign ramBus.req   = wrEn && tRam && !effProg;
  assign ramBus.we    = 1'b1;
  assign ramBus.addr  = {4'h0, ramIdx};
  assign ramBus.wdata = wByte;
  assign romBus.req   = 1'b0;
  assign romBus.we    = 1'b0;
  assign romBus.addr  = effAddr[11:0];
  assign romBus.wdata = 8'h00;

  // ---------------------------------------------------------------
  // Core register writes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr0Low_reg  <= bdm_pkg::RST_BYTE;
      ptr0High_reg <= bdm_pkg::RST_BYTE;
      ptr1Low_reg  <= bdm_pkg::RST_BYTE;
      ptr1High_reg <= bdm_pkg::RST_BYTE;
      bankSel_reg  <= bdm_pkg::RST_BYTE;
      for (int i = 0; i < 3; i++) coreMisc_reg[i] <= bdm_pkg::RST_BYTE;
    end else if (coreWr && state_reg == bdm_pkg::ACC_IDLE) begin
      if (tOfs[3:0] == bdm_pkg::OFS_PTR0_LOW[3:0]) begin
        ptr0Low_reg <= wByte;
      end else if (tOfs[3:0] == bdm_pkg::OFS_PTR0_HIGH[3:0]) begin
        ptr0High_reg <= wByte;
      end else if (tOfs[3:0] == bdm_pkg::OFS_PTR1_LOW[3:0]) begin
        ptr1Low_reg <= wByte;
      end else if (tOfs[3:0] == bdm_pkg::OFS_PTR1_HIGH[3:0]) begin
        ptr1High_reg <= wByte;
      end else if (tOfs[3:0] == bdm_pkg::OFS_BANK_SEL[3:0]) begin
        bankSel_reg <= {3'b000, wByte[4:0]};
      end else if (tOfs[3:0] >= 4'h9) begin
        coreMisc_reg[2'(tOfs[3:0] - 4'h9)] <= wByte;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) convReg_reg[i] <= bdm_pkg::RST_BYTE;
    end else if (wrEn && tConv && !effProg &&
                 state_reg == bdm_pkg::ACC_IDLE) begin
      convReg_reg[convIdx] <= wByte;
    end
  end

  // ---------------------------------------------------------------
  // Answer sequencing
  // ---------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (effProg) begin
      rdMux = romBus.rdata;
    end else if (tCore && tOfs > bdm_pkg::OFS_PORT_ONE) begin
      rdMux = coreRd;
    end else if (tRam) begin
      rdMux = ramBus.rdata;
    end else if (tConv) begin
      rdMux = convReg_reg[convIdx];
    end
  end

  // Program reads pass through the wait state once
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= bdm_pkg::ACC_IDLE;
    end else begin
      case (state_reg)
        bdm_pkg::ACC_IDLE: begin
          if (req && effProg) state_reg <= bdm_pkg::ACC_WAIT;
          else if (req) state_reg <= bdm_pkg::ACC_DONE;
        end
        bdm_pkg::ACC_WAIT: state_reg <= bdm_pkg::ACC_DONE;
        default:           state_reg <= bdm_pkg::ACC_IDLE;
      endcase
    end
  end

  // One-cycle answer, one cycle later for program reads and writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && (state_reg == bdm_pkg::ACC_WAIT ||
                 (state_reg == bdm_pkg::ACC_IDLE && !effProg));
    end
  end

  // Read byte captured when taken, held until next request
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= bdm_pkg::RST_BYTE;
    end else if (req && state_reg != bdm_pkg::ACC_DONE) begin
      if (isInd) rdata_reg <= {7'h00, progSeen_reg};
      else if (isCore) rdata_reg <= rdMux;
      else rdata_reg <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Program access status flag
  // ---------------------------------------------------------------
  // A new program access wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      progSeen_reg <= 1'b0;
    end else if (req && effProg && state_reg == bdm_pkg::ACC_IDLE) begin
      progSeen_reg <= 1'b1;
    end else if (isInd && wrEn) begin
      progSeen_reg <= 1'b0;
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = {24'h000000, rdata_reg};
  assign bankSelect = bankSel_reg[4:0];
  assign progAccess = state_reg == bdm_pkg::ACC_WAIT;
endmodule // banked_data_memory_decode
`default_nettype wire

// [common/bdm_pkg.sv]
// Package: address map, core register offsets and sizes for banked data memory
package bdm_pkg;
  // ---------------------------------------------------------------
  // Core register offsets (within every bank)
  // ---------------------------------------------------------------
  localparam logic [6:0] OFS_PORT_ZERO  = 7'h00;
  localparam logic [6:0] OFS_PORT_ONE   = 7'h01;
  localparam logic [6:0] OFS_PTR0_LOW   = 7'h04;
  localparam logic [6:0] OFS_PTR0_HIGH  = 7'h05;
  localparam logic [6:0] OFS_PTR1_LOW   = 7'h06;
  localparam logic [6:0] OFS_PTR1_HIGH  = 7'h07;
  localparam logic [6:0] OFS_BANK_SEL   = 7'h08;
  localparam logic [6:0] OFS_CORE_LAST  = 7'h0B;
  localparam logic [6:0] OFS_COMMON_LO  = 7'h70;
  localparam logic [6:0] OFS_COMMON_HI  = 7'h7F;
  localparam logic [6:0] OFS_GPR_LO     = 7'h20;
  localparam logic [6:0] OFS_GPR_HI     = 7'h6F;
  localparam logic [6:0] OFS_CONV_LO    = 7'h1B;
  localparam logic [6:0] OFS_CONV_HI    = 7'h1F;
  localparam int         BANK_SPACING   = 'h80;
  localparam logic [4:0] BANK_CONV_MAIN = 5'h01;
  localparam logic [4:0] BANK_CONV_ALIAS = 5'h0E;
  localparam int         GPR_BANKS      = 3;
  localparam int         PROG_SEL_BIT   = 7;
  localparam int         EXTRA_CYCLES   = 1;
  // ---------------------------------------------------------------
  // Wishbone byte addresses (word per location)
  // ---------------------------------------------------------------
  localparam logic [15:0] WB_CORE_BASE  = 16'h0000;
  localparam logic [15:0] WB_IND_CMD    = 16'h8000;
  localparam logic [15:0] WB_IND_STAT   = 16'h8004;
  localparam logic [15:0] WB_PROG_BASE  = 16'hC000;
  // Reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_DONE} acc_state_t;
endpackage

// [common/mem_if.sv]
// Interface: one byte access to an internal storage
`timescale 1ns/100ps
`default_nettype none
interface mem_if #(parameter int AW = 12);
  logic          req;
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport master (output req, output we, output addr, output wdata,
                  input rdata);
  modport slave  (input req, input we, input addr, input wdata,
                  output rdata);
endinterface
`default_nettype wire

// [core/bdm_ram.sv]
// Storage for general purpose and common bytes
`timescale 1ns/100ps
`default_nettype none
module bdm_ram #(
  parameter int DEPTH = 256
) (
  // Clock
  input  wire logic mclk,
  // Access
  mem_if.slave      port
);
  logic [7:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > 4096) begin : gDepthCheck
    $error("bdm_ram depth out of range");
  end

  always_ff @(posedge mclk) begin
    if (port.req && port.we) begin
      mem[port.addr[$clog2(DEPTH)-1:0]] <= port.wdata;
    end
  end

  assign port.rdata = mem[port.addr[$clog2(DEPTH)-1:0]];
endmodule // bdm_ram
`default_nettype wire

// [core/bdm_prog_rom.sv]
// Program memory image, read-only from the data side
`timescale 1ns/100ps
`default_nettype none
module bdm_prog_rom #(
  parameter int DEPTH = 4096,
  parameter int WIDTH = 14
) (
  // Clock
  input  wire logic             mclk,
  // Loader (program side, not reachable from data path)
  input  wire logic             loadEn,
  input  wire logic [11:0]      loadAddr,
  input  wire logic [WIDTH-1:0] loadData,
  // Data-side read
  mem_if.slave                  port
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (WIDTH < 8 || DEPTH > 4096) begin : gShapeCheck
    $error("bdm_prog_rom bad shape");
  end

  always_ff @(posedge mclk) begin
    if (loadEn) begin
      mem[loadAddr] <= loadData;
    end
  end

  // Only low byte leaves the memory
  assign port.rdata = mem[port.addr[11:0]][7:0];
endmodule // bdm_prog_rom
`default_nettype wire

// [bench/core_master.sv]
// Processor-side model issuing data accesses over classic Wishbone
`timescale 1ns/100ps
`default_nettype none
module core_master (
  // Clock
  input  wire logic        mclk,
  // Bus request
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [15:0]      adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat,
  // Bus answer
  input  wire logic        ack,
  input  wire logic [31:0] rdat
);
  initial begin
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 16'h0000;
    sel  = 4'h0;
    wdat = 32'h00000000;
  end

  // Holds the request until ack; n counts edges up to the answer
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output int n);
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc  <= 1'b0;
    stb  <= 1'b0;
    wdat <= ~wdat;
  endtask
endmodule // core_master
`default_nettype wire

// [bench/banked_data_memory_decode_monitor.sv]
// Concurrent checks on the decoder's bus and status ports
`timescale 1ns/100ps
`default_nettype none
module bdm_check (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Status
  input wire logic [4:0]  bankSelect,
  input wire logic        progAccess
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic bankWr = req && wb_we_i && wb_sel_i[0] && !wb_ack_o &&
                      wb_adr_i == 16'h0020;
  sequence s_start;
    $rose(req);
  endsequence
  sequence s_stall;
    s_start ##1 progAccess;
  endsequence

  a_first_answer: assert property (s_start |=> wb_ack_o ^ progAccess)
    else $error("no answer one cycle after request");
  a_prog_extra: assert property (s_stall |=> wb_ack_o && !progAccess)
    else $error("program access not answered after extra cycle");
  a_stall_quiet: assert property (progAccess |-> !wb_ack_o && req)
    else $error("ack during extra cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_idle_no_ack: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data above low byte not zero");
  a_data_hold: assert property (!req && !wb_ack_o |=> $stable(wb_dat_o))
    else $error("read data changed while idle");
  a_bank_write: assert property (bankWr |=>
    wb_ack_o && bankSelect == $past(wb_dat_i[4:0]))
    else $error("bank selector write not applied");
  a_bank_hold: assert property (!(req && wb_we_i) |=> $stable(bankSelect))
    else $error("bank selector changed without write");
endmodule // bdm_check

bind banked_data_memory_decode bdm_check u_check (.mclk(mclk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bankSelect(bankSelect),
  .progAccess(progAccess));
`default_nettype wire

// [bench/banked_data_memory_decode_test.sv]
// Self-checking bench for the banked data memory decoder
`timescale 1ns/100ps
`default_nettype none
module banked_data_memory_decode_test;
  localparam int LN = 2;
  localparam int LP = 3;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, progAccess;
  logic [15:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [4:0]  bankSelect;
  logic        loadEn = 1'b0;
  logic [11:0] loadAddr = 12'h000;
  logic [13:0] loadData = 14'h0000;
  int          miscompares = 0;
  int          n_tests = 0;

  always #2.5 mclk = ~mclk;

  banked_data_memory_decode dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .progLoadEn(loadEn),
    .progLoadAddr(loadAddr), .progLoadData(loadData),
    .bankSelect(bankSelect), .progAccess(progAccess));
  core_master m (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .wdat(wdat), .ack(ack), .rdat(rdat));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access to location loc; checks answer time and read byte
  task automatic acc(input logic w, input logic [11:0] loc,
                     input logic [7:0] d, input logic [7:0] e, input int el);
    logic [7:0] q;
    int         n;
    m.xfer(w, {2'b00, loc, 2'b00}, d, q, n);
    chk(n, el);
    if (!w) chk({24'h000000, q}, {24'h000000, e});
  endtask

  task automatic t_core_banks();
    for (int b = 0; b < 32; b++) begin
      acc(1'b1, {b[4:0], 7'h09}, {3'b101, b[4:0]}, 8'h00, LN);
      acc(1'b0, {~b[4:0], 7'h09}, 8'h00, {3'b101, b[4:0]}, LN);
    end
    acc(1'b1, 12'h108, 8'h0E, 8'h00, LN);
    chk({27'h0000000, bankSelect}, 32'h0000000E);
    acc(1'b0, 12'hF88, 8'h00, 8'h0E, LN);
  endtask

  task automatic t_common();
    for (int b = 0; b < 32; b++) begin
      acc(1'b1, {b[4:0], 3'h7, b[3:0]}, {3'b110, b[4:0]}, 8'h00, LN);
      acc(1'b0, {~b[4:0], 3'h7, b[3:0]}, 8'h00, {3'b110, b[4:0]}, LN);
    end
  endtask

  task automatic t_unimpl();
    logic [11:0] locs [5] = '{12'h002, 12'h00F, 12'h1A0, 12'h3A0, 12'h11B};
    logic [7:0]  q;
    int          n;
    foreach (locs[i]) begin
      acc(1'b1, locs[i], 8'hFF, 8'h00, LN);
      acc(1'b0, locs[i], 8'h00, 8'h00, LN);
    end
    m.xfer(1'b0, 16'h4000, 8'h00, q, n);
    chk({24'h000000, q}, 32'h00000000);
  endtask

  task automatic t_conv();
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, 12'h09B + k[11:0], 8'h30 + k[7:0], 8'h00, LN);
      acc(1'b0, 12'h71B + k[11:0], 8'h00, 8'h30 + k[7:0], LN);
    end
    acc(1'b1, 12'h71F, 8'hA5, 8'h00, LN);
    acc(1'b0, 12'h09F, 8'h00, 8'hA5, LN);
  endtask

  task automatic t_indirect();
    acc(1'b1, 12'h008, 8'h05, 8'h00, LN);
    acc(1'b1, 12'h004, 8'h23, 8'h00, LN);
    acc(1'b1, 12'h005, 8'h01, 8'h00, LN);
    acc(1'b1, 12'h000, 8'h77, 8'h00, LN);
    acc(1'b0, 12'h123, 8'h00, 8'h77, LN);
    acc(1'b1, 12'h123, 8'h3C, 8'h00, LN);
    acc(1'b0, 12'h280, 8'h00, 8'h3C, LN);
  endtask

  task automatic t_prog();
    acc(1'b1, 12'h006, 8'h23, 8'h00, LN);
    acc(1'b1, 12'h007, 8'h81, 8'h00, LN);
    acc(1'b0, 12'h001, 8'h00, 8'hBC, LP);
    acc(1'b1, 12'h081, 8'h55, 8'h00, LP);
    acc(1'b0, 12'h381, 8'h00, 8'hBC, LP);
    acc(1'b0, 12'h123, 8'h00, 8'h3C, LN);
    acc(1'b0, 12'h000, 8'h00, 8'h3C, LN);
  endtask

  task automatic t_status();
    logic [7:0] q;
    int         n;
    m.xfer(1'b0, 16'h8000, 8'h00, q, n);
    chk(n, LN);
    chk({24'h000000, q}, 32'h00000001);
    m.xfer(1'b1, 16'h8004, 8'h00, q, n);
    m.xfer(1'b0, 16'h8000, 8'h00, q, n);
    chk({24'h000000, q}, 32'h00000000);
  endtask

  task automatic t_reset();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk({27'h0000000, bankSelect}, 32'h00000000);
    acc(1'b0, 12'h001, 8'h00, 8'h00, LN);
    acc(1'b0, 12'h005, 8'h00, 8'h00, LN);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    loadEn <= 1'b1;
    loadAddr <= 12'h123;
    loadData <= 14'h2ABC;
    @(posedge mclk);
    loadEn <= 1'b0;
    t_core_banks();
    t_common();
    t_unimpl();
    t_conv();
    t_indirect();
    t_prog();
    t_status();
    t_reset();
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
endmodule // banked_data_memory_decode_test
`default_nettype wire
